// ===== verilog/ptmr_pkg.sv
// Purpose: Constants, types and field layout of the periodic timer.
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses.
// Notes:   Unused register bits read as zero.
package ptmr_pkg;

    localparam logic [7:0] PTMR_OFF_CTRL0  = 8'h00;
    localparam logic [7:0] PTMR_OFF_CTRL1  = 8'h04;
    localparam logic [7:0] PTMR_OFF_COUNT  = 8'h08;
    localparam logic [7:0] PTMR_OFF_CMPA   = 8'h0C;
    localparam logic [7:0] PTMR_OFF_PERIOD = 8'h10;
    localparam logic [7:0] PTMR_OFF_STATUS = 8'h14;

    localparam int PTMR_CTRL0_EN_BIT   = 3;
    localparam int PTMR_CTRL0_PRE_LSB  = 0;
    localparam int PTMR_STAT_A_BIT     = 0;
    localparam int PTMR_STAT_P_BIT     = 1;

    localparam logic [7:0]  PTMR_CTRL1_RESET = 8'h00;
    localparam logic [9:0]  PTMR_CNT_MAX     = 10'h3FF;
    localparam logic [10:0] PTMR_FULL_PERIOD = 11'h400;

    typedef enum logic [1:0] {
        PTMR_MODE_CMP   = 2'h0,
        PTMR_MODE_CAP   = 2'h1,
        PTMR_MODE_PWM   = 2'h2,
        PTMR_MODE_TIMER = 2'h3
    } ptmr_mode_e;

    typedef struct packed {
        ptmr_mode_e mode;
        logic [1:0] out_fn;
        logic       init_level;
        logic       invert;
        logic       cap_src;
        logic       clr_sel;
    } ptmr_ctrl1_s;

    typedef struct packed {
        ptmr_ctrl1_s ctrl1;
        logic        enable;
        logic [2:0]  prescale;
        logic [9:0]  cmpa;
        logic [9:0]  period;
        logic [9:0]  cnt;
        logic        flag_a;
        logic        flag_p;
        logic        io_prev;
        logic        ext_prev;
        logic        pin_level;
        logic [6:0]  div;
        logic        ack;
        logic [31:0] dat;
        logic        io_out;
        logic        io_oe_n;
    } ptmr_state_s;

endpackage

// ===== verilog/ptmr_top.sv
// Purpose: Ten-bit periodic timer with compare, PWM, pulse and capture.
// Assumes: Pins synchronous to clk; one clock; synchronous reset.
// Notes:   Timer tick is clk divided by 2^prescale.
`timescale 1ns/1ps
`default_nettype none
module ptmr_top
    import ptmr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        timer_io_pin_i,
    output logic             timer_io_pin_o,
    output logic             timer_io_pin_oe_n,
    input  wire logic        external_clock_pin,
    output logic             match_a_flag,
    output logic             match_p_flag
);

    ptmr_state_s q;
    ptmr_state_s d;

    logic        acc;
    logic        wr;
    logic [7:0]  wadr;
    logic [6:0]  div_mask;
    logic        tick;
    logic        cmp_like;
    logic        pwm_mode;
    logic        pulse_mode;
    logic        cap_mode;
    logic [10:0] cnt_inc;
    logic [10:0] eff_period;
    logic        hit_a;
    logic        hit_p;
    logic        cap_in;
    logic        cap_prev;
    logic        cap_edge;
    logic        pwm_active;

    assign acc        = wb_cyc_i & wb_stb_i & ~q.ack;
    assign wr         = acc & wb_we_i;
    assign wadr       = {wb_adr_i[7:2], 2'b00};
    assign div_mask   = 7'((8'h01 << q.prescale) - 8'h01);
    assign tick       = (q.div & div_mask) == div_mask;
    assign cmp_like   = (q.ctrl1.mode == PTMR_MODE_CMP) | (q.ctrl1.mode == PTMR_MODE_TIMER);
    assign pwm_mode   = (q.ctrl1.mode == PTMR_MODE_PWM) & (q.ctrl1.out_fn != 2'h3);
    assign pulse_mode = (q.ctrl1.mode == PTMR_MODE_PWM) & (q.ctrl1.out_fn == 2'h3);
    assign cap_mode   = q.ctrl1.mode == PTMR_MODE_CAP;
    assign cnt_inc    = {1'b0, q.cnt} + 11'h001;
    assign eff_period = (q.period == 10'h000) ? PTMR_FULL_PERIOD : {1'b0, q.period};
    // Match on the count about to be reached; compare A zero never matches
    assign hit_a      = (q.cmpa != 10'h000) & (cnt_inc == {1'b0, q.cmpa});
    assign hit_p      = cnt_inc == eff_period;
    assign cap_in     = q.ctrl1.cap_src ? external_clock_pin : timer_io_pin_i;
    assign cap_prev   = q.ctrl1.cap_src ? q.ext_prev : q.io_prev;
    assign pwm_active = (q.cmpa >= eff_period[9:0] && eff_period != PTMR_FULL_PERIOD)
                      | (q.cnt < q.cmpa);

    always_comb begin
        case (q.ctrl1.out_fn)
            2'h0:    cap_edge = cap_in & ~cap_prev;
            2'h1:    cap_edge = ~cap_in & cap_prev;
            2'h2:    cap_edge = cap_in ^ cap_prev;
            default: cap_edge = 1'b0;
        endcase
    end

    always_comb begin
        d          = q;
        d.ack      = acc;
        d.dat      = 32'h0000_0000;
        d.div      = q.div + 7'h01;
        d.io_prev  = timer_io_pin_i;
        d.ext_prev = external_clock_pin;

        // Register reads
        if (acc && !wb_we_i) begin
            case (wadr)
                PTMR_OFF_CTRL0:  d.dat = {28'h0000000, q.enable, q.prescale};
                PTMR_OFF_CTRL1:  d.dat = {24'h000000, q.ctrl1};
                PTMR_OFF_COUNT:  d.dat = {22'h000000, q.cnt};
                PTMR_OFF_CMPA:   d.dat = {22'h000000, q.cmpa};
                PTMR_OFF_PERIOD: d.dat = {22'h000000, q.period};
                PTMR_OFF_STATUS: d.dat = {30'h00000000, q.flag_p, q.flag_a};
                default:         d.dat = 32'h0000_0000;
            endcase
        end

        // Register writes
        if (wr && wb_sel_i[0]) begin
            case (wadr)
                PTMR_OFF_CTRL0: begin
                    d.enable   = wb_dat_i[PTMR_CTRL0_EN_BIT];
                    d.prescale = wb_dat_i[PTMR_CTRL0_PRE_LSB +: 3];
                end
                PTMR_OFF_CTRL1:  d.ctrl1 = ptmr_ctrl1_s'(wb_dat_i[7:0]);
                PTMR_OFF_CMPA:   d.cmpa[7:0] = wb_dat_i[7:0];
                PTMR_OFF_PERIOD: d.period[7:0] = wb_dat_i[7:0];
                PTMR_OFF_STATUS: begin
                    if (wb_dat_i[PTMR_STAT_A_BIT]) begin
                        d.flag_a = 1'b0;
                    end
                    if (wb_dat_i[PTMR_STAT_P_BIT]) begin
                        d.flag_p = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (wr && wb_sel_i[1]) begin
            case (wadr)
                PTMR_OFF_CMPA:   d.cmpa[9:8] = wb_dat_i[9:8];
                PTMR_OFF_PERIOD: d.period[9:8] = wb_dat_i[9:8];
                default: begin
                end
            endcase
        end

        // External pin rising edge starts a pulse
        if (pulse_mode && external_clock_pin && !q.ext_prev) begin
            d.enable = 1'b1;
        end

        if (d.enable && !q.enable) begin
            d.cnt       = 10'h000;
            d.pin_level = q.ctrl1.init_level;
        end else if (q.enable && tick) begin
            d.cnt = q.cnt + 10'h001;
            if (cmp_like) begin
                if (q.ctrl1.clr_sel) begin
                    if (hit_a || cnt_inc == PTMR_FULL_PERIOD) begin
                        d.cnt = 10'h000;
                    end
                end else if (hit_p) begin
                    d.cnt    = 10'h000;
                    d.flag_p = 1'b1;
                end
                if (hit_a) begin
                    d.flag_a = 1'b1;
                    case (q.ctrl1.out_fn)
                        2'h1:    d.pin_level = 1'b0;
                        2'h2:    d.pin_level = 1'b1;
                        2'h3:    d.pin_level = ~q.pin_level;
                        default: d.pin_level = q.pin_level;
                    endcase
                end
            end else if (pwm_mode) begin
                if (hit_p) begin
                    d.cnt    = 10'h000;
                    d.flag_p = 1'b1;
                end
                if (hit_a) begin
                    d.flag_a = 1'b1;
                end
            end else if (pulse_mode) begin
                if (hit_a) begin
                    d.enable = 1'b0;
                    d.flag_a = 1'b1;
                end
            end else if (cap_mode) begin
                if (hit_p) begin
                    d.cnt    = 10'h000;
                    d.flag_p = 1'b1;
                end
            end
        end

        // Capture while the counter runs
        if (cap_mode && q.enable && cap_edge) begin
            d.cmpa   = q.cnt;
            d.flag_a = 1'b1;
        end

        // Pin drive, registered
        d.io_oe_n = 1'b1;
        d.io_out  = 1'b0;
        if (q.ctrl1.mode == PTMR_MODE_CMP) begin
            d.io_oe_n = 1'b0;
            d.io_out  = d.pin_level ^ q.ctrl1.invert;
        end else if (pwm_mode) begin
            d.io_oe_n = 1'b0;
            case (q.ctrl1.out_fn)
                2'h0:    d.io_out = ~q.ctrl1.init_level ^ q.ctrl1.invert;
                2'h1:    d.io_out = q.ctrl1.init_level ^ q.ctrl1.invert;
                default: d.io_out = (pwm_active ~^ q.ctrl1.init_level) ^ q.ctrl1.invert;
            endcase
        end else if (pulse_mode) begin
            d.io_oe_n = 1'b0;
            d.io_out  = (d.enable ~^ q.ctrl1.init_level) ^ q.ctrl1.invert;
        end

        if (srst) begin
            d          = '0;
            d.ctrl1    = ptmr_ctrl1_s'(PTMR_CTRL1_RESET);
            d.io_oe_n  = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign wb_dat_o          = q.dat;
    assign wb_ack_o          = q.ack;
    assign timer_io_pin_o    = q.io_out;
    assign timer_io_pin_oe_n = q.io_oe_n;
    assign match_a_flag      = q.flag_a;
    assign match_p_flag      = q.flag_p;

endmodule
`default_nettype wire

// ===== verification/ptmr_checker.sv
// Purpose: Port assertions of the periodic timer.
// Assumes: Control byte tracked from acked bus writes.
// Notes:   Bound to the top module.
`timescale 1ns/1ps
`default_nettype none
module ptmr_checker (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        timer_io_pin_o,
    input wire logic        timer_io_pin_oe_n,
    input wire logic        match_a_flag,
    input wire logic        match_p_flag
);
    logic [7:0] c1_q;
    logic       st_wr;
    assign st_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i[7:2] == 6'h05;
    always_ff @(posedge clk) begin
        if (srst) begin
            c1_q <= 8'h00;
        end else if (wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h01) begin
            c1_q <= wb_dat_i[7:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    ack_one_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_answers_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    a_flag_hold_a: assert property ($fell(match_a_flag) |-> $past(st_wr && wb_dat_i[0]))
        else $error("A flag dropped without clear");
    p_flag_hold_a: assert property ($fell(match_p_flag) |-> $past(st_wr && wb_dat_i[1]))
        else $error("P flag dropped without clear");
    no_p_flag_a: assert property (c1_q[0] && c1_q[7] == c1_q[6] && $stable(c1_q)
        |-> !$rose(match_p_flag)) else $error("P flag with clear on A");
    no_capture_a: assert property (c1_q[7:4] == 4'h7 && $stable(c1_q)
        |-> !$rose(match_a_flag)) else $error("capture while disabled");
    pin_free_a: assert property (c1_q[6] && $stable(c1_q) |-> timer_io_pin_oe_n)
        else $error("pin driven in timer or capture mode");
    forced_level_a: assert property (c1_q[7:5] == 3'h4 && $stable(c1_q)
        |-> timer_io_pin_o == ((c1_q[4] ~^ c1_q[3]) ^ c1_q[2])) else $error("forced level wrong");
endmodule
bind ptmr_top ptmr_checker i_chk (
    .clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .timer_io_pin_o(timer_io_pin_o), .timer_io_pin_oe_n(timer_io_pin_oe_n),
    .match_a_flag(match_a_flag), .match_p_flag(match_p_flag)
);
`default_nettype wire

// ===== verification/ptmr_pins.sv
// Purpose: Pin side model: trigger source and io wire.
// Assumes: Trigger pulse is two clocks high.
// Notes:   Undriven io wire follows the trigger level.
`timescale 1ns/1ps
`default_nettype none
module ptmr_pins (
    input  wire logic clk,
    input  wire logic fire,
    input  wire logic pin_o,
    input  wire logic oe_n,
    output logic      ext_pin,
    output logic      io_in
);
    logic [1:0] hold_q = 2'h0;
    always_ff @(posedge clk) begin
        hold_q <= fire ? 2'h3 : {hold_q[0], 1'b0};
    end
    assign ext_pin = hold_q[1];
    assign io_in   = oe_n ? hold_q[1] : pin_o;
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Purpose: Register level tests of the periodic timer.
// Assumes: Prescale 0, one tick per clock.
// Notes:   Pin trigger comes from the pin model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ptmr_pkg::*;
    logic        clk, srst, req, we, fire, ack, pin, oe_n, ext, io_in, fa, fp;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, rd, c;
    int          n_fail, checks, cycles, hi;
    logic [31:0] cfg [3] = '{32'h20, 32'h18, 32'h08};
    ptmr_top i_dut (
        .clk(clk), .srst(srst), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .timer_io_pin_i(io_in), .timer_io_pin_o(pin), .timer_io_pin_oe_n(oe_n),
        .external_clock_pin(ext), .match_a_flag(fa), .match_p_flag(fp)
    );
    ptmr_pins i_pins (.clk(clk), .fire(fire), .pin_o(pin), .oe_n(oe_n), .ext_pin(ext),
        .io_in(io_in));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            tally_and_finish;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rd = rdat;
        req <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic hic(input int n);
        hi = 0;
        repeat (n) begin
            @(posedge clk);
            hi += int'(pin === 1'b1);
        end
    endtask
    task automatic trig;
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask
    task automatic run(input logic [31:0] c1, input logic [31:0] cmpa);
        wr(PTMR_OFF_CTRL0, 32'h0);
        wr(PTMR_OFF_STATUS, 32'h3);
        wr(PTMR_OFF_CTRL1, c1);
        wr(PTMR_OFF_CMPA, cmpa);
    endtask
    initial begin
        srst = 1'b1;
        {req, we, fire, adr, wdat} = '0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rdc(PTMR_OFF_CTRL1, 32'(PTMR_CTRL1_RESET));
        rdc(8'h3C, 32'h0);
        $display("Test reset done");
        wr(PTMR_OFF_PERIOD, 32'h5);
        for (int i = 0; i < 3; i++) begin
            run(cfg[i], 32'h2);
            wr(PTMR_OFF_CTRL0, 32'h8);
            repeat (20) @(posedge clk);
            chk(32'(pin), 32'(i != 1));
        end
        rdc(PTMR_OFF_STATUS, 32'h3);
        run(32'h31, 32'h2);
        wr(PTMR_OFF_CTRL0, 32'h8);
        repeat (20) @(posedge clk);
        rdc(PTMR_OFF_STATUS, 32'h1);
        wr(PTMR_OFF_CTRL0, 32'h0);
        bus(1'b0, PTMR_OFF_COUNT, 32'h0);
        c = rd;
        repeat (5) @(posedge clk);
        rdc(PTMR_OFF_COUNT, c);
        run(32'hC1, 32'h0);
        wr(PTMR_OFF_CTRL0, 32'h8);
        repeat (20) @(posedge clk);
        rdc(PTMR_OFF_STATUS, 32'h0);
        $display("Test compare done");
        wr(PTMR_OFF_PERIOD, 32'h4);
        run(32'hA8, 32'h1);
        wr(PTMR_OFF_CTRL0, 32'h8);
        hic(40);
        chk(hi, 10);
        wr(PTMR_OFF_CMPA, 32'h4);
        repeat (4) @(posedge clk);
        hic(40);
        chk(hi, 40);
        rdc(PTMR_OFF_STATUS, 32'h3);
        run(32'hAC, 32'h1);
        wr(PTMR_OFF_CTRL0, 32'h8);
        hic(40);
        chk(hi, 30);
        run(32'h80, 32'h1);
        repeat (3) @(posedge clk);
        chk(32'(pin), 32'h1);
        $display("Test pwm done");
        run(32'hB8, 32'h6);
        trig;
        hic(30);
        chk(32'(hi >= 5 && hi <= 7), 32'h1);
        rdc(PTMR_OFF_CTRL0, 32'h0);
        chk(32'({fp, fa}), 32'h1);
        rdc(PTMR_OFF_COUNT, 32'h6);
        $display("Test pulse done");
        wr(PTMR_OFF_PERIOD, 32'h0);
        run(32'h42, 32'h1);
        wr(PTMR_OFF_CTRL0, 32'h8);
        repeat (10) @(posedge clk);
        trig;
        repeat (6) @(posedge clk);
        bus(1'b0, PTMR_OFF_CMPA, 32'h0);
        chk(32'(rd > 8 && rd < 20), 32'h1);
        run(32'h60, 32'h1);
        wr(PTMR_OFF_CTRL0, 32'h8);
        trig;
        repeat (6) @(posedge clk);
        bus(1'b0, PTMR_OFF_CMPA, 32'h0);
        chk(rd, 32'h5);
        wr(PTMR_OFF_CTRL1, 32'h72);
        wr(PTMR_OFF_PERIOD, 32'h3);
        wr(PTMR_OFF_CTRL0, 32'h0);
        wr(PTMR_OFF_CTRL0, 32'h8);
        wr(PTMR_OFF_STATUS, 32'h3);
        trig;
        repeat (6) @(posedge clk);
        rdc(PTMR_OFF_STATUS, 32'h2);
        $display("Test capture done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
